/* File: design/scl_map.svh */
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH
// Notes on behaviour
// [R1] with a valid image in flash, active loading starts alone after power-up
// [R2] rising config_reset_n after a held low restarts active loading from flash
// [R3] active mode makes its own serial clock and runs the whole load sequence
// [R4] the first flash instruction of a load is the wake-from-power-down command
// [R5] at least 30 us pass after the wake command before any read is issued
// [R6] then a fast read starts at address zero and reads on sequentially
// [R7] received bytes program config_ram_cells; done rises only when all are taken
// [R8] in passive mode an outside master drives clock, control and data; here passive mode only keeps the loader idle and loads nothing
// [R9] active loading works at x1, x2 and x4; other widths are refused here
// [R10] in user mode fabric drives clock, data, wp, pause and select; miso returns
// [R11] whoever clocks the flash keeps that clock at or below 20 MHz
// [R12] fabric uses the flash port only when no lvds transmitter is in use
// [R13] fabric keeps flash addresses inside the 16 Mbit capacity
// [R14] on the combined package config select must be wired to flash select
// [R15] commands go as 8-bit opcode, 24-bit address msb first, then dummy clocks

// clock and timing
`define SCL_CLK_PS 32'd8000
`define SCL_WAKE_US 32'd30
`define SCL_SPI_MHZ 32'd20
`define SCL_WAKE_CYC ((`SCL_WAKE_US * 32'd1000000 + `SCL_CLK_PS - 32'd1) / `SCL_CLK_PS)
`define SCL_HALF_CYC ((32'd1000000 / (32'd2 * `SCL_SPI_MHZ) + `SCL_CLK_PS - 32'd1) / `SCL_CLK_PS)

// flash commands and framing
`define SCL_OP_WAKE 8'hab
`define SCL_OP_READ1 8'h0b
`define SCL_OP_READ2 8'h3b
`define SCL_OP_READ4 8'h6b
`define SCL_ADDR0 24'h000000
`define SCL_CMD_BITS 6'h20
`define SCL_OP_BITS 6'h08
`define SCL_DUMMY 6'h08

// io lane positions
`define SCL_IO_MOSI 0
`define SCL_IO_MISO 1

// reset values
`define SCL_PEND_RST 1'b1
`endif

/* File: design/scl_pkg.sv */
package scl_pkg;
    typedef enum logic [2:0] {S_IDLE, S_WAKE, S_GAP, S_CMD, S_DUMMY, S_DATA, S_DONE} scl_state_e;
    typedef enum logic [1:0] {M_ACTIVE, M_PASSIVE, M_JTAG} scl_mode_e;
    typedef enum logic [2:0] {W_X1, W_X2, W_X4, W_X8, W_X16, W_X32} scl_width_e;

    // fabric side of the user-mode flash port
    typedef struct packed {
        logic sclk;
        logic mosi;
        logic wp_n;
        logic flash_pause_n;
        logic flash_select_n;
    } scl_user_s;

    // flash pins; io lanes are mosi, miso, wp_n, pause_n
    typedef struct packed {
        logic sclk;
        logic flash_select_n;
        logic [3:0] io_o;
        logic [3:0] io_oe_n;
    } scl_flash_s;

    // loader state
    typedef struct packed {
        scl_state_e st;
        logic cr1;
        logic cr2;
        logic crp;
        logic [3:0] io1;
        logic [3:0] io2;
        logic pend;
        logic [3:0] div;
        logic sclk;
        logic sel_n;
        logic [31:0] sh;
        logic [5:0] bits;
        logic [15:0] wcnt;
        logic [7:0] rx;
        logic [3:0] rxn;
        logic [31:0] nbytes;
        logic push;
        logic done;
        logic err;
    } scl_reg_s;
endpackage

/* File: design/scl_loader.sv */
`timescale 1ns/1ps
`include "scl_map.svh"

////////////////////////////////////////////////////////////////////////////////
module scl_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } scl_ptr_s;
    scl_ptr_s q;
    scl_ptr_s d;
    logic [W-1:0] mem [D];
    logic full;
    logic empty;
    if (D < 2 || (1 << AW) != D) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end
    // full when pointers differ only in the wrap bit
    assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
    assign empty = q.wp == q.rp;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[q.rp[AW-1:0]];
    always_comb begin
        d = q;
        if (in_valid && !full) begin
            d.wp = q.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            d.rp = q.rp + 1'b1;
        end
    end
    // storage has no reset; only the pointers need a defined start
    always_ff @(posedge mclk) begin
        if (in_valid && !full) begin
            mem[q.wp[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module scl_loader #(
    parameter logic [31:0] IMG_BYTES = 32'd1024,
    parameter int HALF_CYC = `SCL_HALF_CYC,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic config_reset_n,
    input wire scl_pkg::scl_mode_e cfg_mode,
    input wire scl_pkg::scl_width_e cfg_width,
    input wire scl_pkg::scl_user_s user,
    output logic user_miso,
    output scl_pkg::scl_flash_s flash,
    input wire logic [3:0] flash_io_i,
    output logic config_ram_cells_valid,
    output logic [7:0] config_ram_cells_data,
    input wire logic config_ram_cells_ready,
    output logic config_done,
    output logic config_error
);
    import scl_pkg::*;
    localparam logic [3:0] DIV_END = 4'(HALF_CYC - 1);
    localparam logic [15:0] WAKE_END = 16'(`SCL_WAKE_CYC - 32'd1);
    // a slower divider only lowers the flash clock, a faster one breaks it
    if (HALF_CYC < `SCL_HALF_CYC || HALF_CYC > 15) begin : g_bad_div
        $error("serial clock half period out of range");
    end
    if (IMG_BYTES == 32'd0) begin : g_bad_img
        $error("image length must be non-zero");
    end
    scl_reg_s q;
    scl_reg_s d;
    logic fifo_ready;
    logic fifo_empty;
    logic run;
    logic tick;
    logic rise;
    logic fall;
    logic width_ok;
    logic [7:0] opcode;
    logic [3:0] step;
    logic [7:0] rx_nx;
    logic user_mode;
    ////////////////////////////////////////////////////////////////////////////
    // width decode: only the three active widths are served
    always_comb begin
        width_ok = 1'b1;
        opcode = `SCL_OP_READ1;
        step = 4'h1;
        unique case (cfg_width)
            W_X1: opcode = `SCL_OP_READ1; // R9
            W_X2: begin
                opcode = `SCL_OP_READ2;
                step = 4'h2;
            end
            W_X4: begin
                opcode = `SCL_OP_READ4;
                step = 4'h4;
            end
            default: width_ok = 1'b0; // R9
        endcase
    end
    // bits arrive msb first; dual and quad take io1/io3 as the high bit
    always_comb begin
        unique case (step)
            4'h2: rx_nx = {q.rx[5:0], q.io2[1:0]};
            4'h4: rx_nx = {q.rx[3:0], q.io2[3:0]};
            default: rx_nx = {q.rx[6:0], q.io2[`SCL_IO_MISO]};
        endcase
    end
    ////////////////////////////////////////////////////////////////////////////
    // clock divider: in the data phase it stalls while the fifo is full,
    // so back-pressure from config ram simply slows the flash clock
    assign run = (q.st == S_WAKE) || (q.st == S_CMD) || (q.st == S_DUMMY) ||
                 ((q.st == S_DATA) && fifo_ready);
    assign tick = run && (q.div == DIV_END); // R3
    assign rise = tick && !q.sclk;
    assign fall = tick && q.sclk;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        d = q;
        d.push = 1'b0;
        d.cr1 = config_reset_n;
        d.cr2 = q.cr1;
        d.crp = q.cr2;
        d.io1 = flash_io_i;
        d.io2 = q.io1;
        d.div = (run && !tick) ? q.div + 4'h1 : 4'h0;
        if (tick) begin
            d.sclk = !q.sclk;
        end
        if (q.cr2 && !q.crp) begin
            d.pend = 1'b1; // R2
        end
        unique case (q.st)
            S_IDLE: begin
                if (q.pend && q.cr2 && cfg_mode == M_ACTIVE) begin
                    d.pend = 1'b0;
                    if (width_ok) begin
                        d.st = S_WAKE; // R1
                        d.sel_n = 1'b0;
                        d.sh = {`SCL_OP_WAKE, 24'h000000}; // R4
                        d.bits = `SCL_OP_BITS;
                        d.err = 1'b0;
                    end else begin
                        d.err = 1'b1; // R9
                    end
                end
            end
            S_WAKE: begin
                if (fall) begin
                    d.sh = {q.sh[30:0], 1'b0}; // R15
                    d.bits = q.bits - 6'h1;
                    if (q.bits == 6'h1) begin
                        d.st = S_GAP;
                        d.sel_n = 1'b1;
                        d.wcnt = WAKE_END; // R5
                    end
                end
            end
            S_GAP: begin
                // select stays high the whole wait so the wake command completes
                d.wcnt = q.wcnt - 16'h1;
                if (q.wcnt == 16'h0) begin
                    d.st = S_CMD; // R5
                    d.sel_n = 1'b0;
                    d.sh = {opcode, `SCL_ADDR0}; // R6
                    d.bits = `SCL_CMD_BITS;
                end
            end
            S_CMD: begin
                if (fall) begin
                    d.sh = {q.sh[30:0], 1'b0}; // R15
                    d.bits = q.bits - 6'h1;
                    if (q.bits == 6'h1) begin
                        d.st = S_DUMMY;
                        d.bits = `SCL_DUMMY; // R15
                    end
                end
            end
            S_DUMMY: begin
                if (fall) begin
                    d.bits = q.bits - 6'h1;
                    if (q.bits == 6'h1) begin
                        d.st = S_DATA;
                        d.rxn = 4'h0;
                        d.nbytes = 32'h0;
                    end
                end
            end
            S_DATA: begin
                if (rise) begin
                    d.rx = rx_nx;
                    d.rxn = q.rxn + step;
                    if (q.rxn + step == 4'h8) begin
                        d.rxn = 4'h0;
                        d.push = 1'b1; // R7
                        d.nbytes = q.nbytes + 32'h1; // R6
                        if (q.nbytes == IMG_BYTES - 32'h1) begin
                            d.st = S_DONE;
                            d.sel_n = 1'b1;
                            d.sclk = 1'b0;
                        end
                    end
                end
            end
            S_DONE: d.done = fifo_empty && !q.push; // R7
        endcase
        // a low config reset aborts any load; its rise starts the next one
        if (!q.cr2) begin
            d.st = S_IDLE; // R2
            d.sel_n = 1'b1;
            d.sclk = 1'b0;
            d.done = 1'b0;
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.st <= S_IDLE;
            q.pend <= `SCL_PEND_RST; // R1
            q.sel_n <= 1'b1;
        end else begin
            q <= d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // bitstream buffer toward config ram
    scl_fifo #(
        .W(8),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rstn(rstn),
        .in_valid(q.push),
        .in_ready(fifo_ready),
        .in_data(q.rx),
        .out_valid(config_ram_cells_valid),
        .out_ready(config_ram_cells_ready),
        .out_data(config_ram_cells_data)
    );
    assign fifo_empty = !config_ram_cells_valid;
    ////////////////////////////////////////////////////////////////////////////
    // pin mux: after loading the fabric owns the flash port
    assign user_mode = q.done;
    assign config_done = q.done; // R7
    assign config_error = q.err;
    assign user_miso = q.io2[`SCL_IO_MISO]; // R10
    always_comb begin
        if (user_mode) begin
            flash.sclk = user.sclk; // R10
            flash.flash_select_n = user.flash_select_n;
            flash.io_o = {user.flash_pause_n, user.wp_n, 1'b0, user.mosi};
            flash.io_oe_n = 4'b0010;
        end else begin
            flash.sclk = q.sclk;
            flash.flash_select_n = q.sel_n;
            // wp and pause held high unless quad reading owns those lanes
            flash.io_o = {2'b11, 1'b0, q.sh[31]};
            flash.io_oe_n[`SCL_IO_MOSI] = !((q.st == S_WAKE) || (q.st == S_CMD));
            flash.io_oe_n[`SCL_IO_MISO] = 1'b1;
            flash.io_oe_n[3:2] = ((q.st == S_DUMMY || q.st == S_DATA) && step == 4'h4) ? 2'b11 : 2'b00;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [15:0] gap_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gap_q <= 16'h0;
        end else begin
            gap_q <= (q.st == S_GAP) ? gap_q + 16'h1 : 16'h0;
        end
    end
    sequence s_wake_done;
        q.st == S_WAKE ##1 q.st == S_GAP;
    endsequence
    sequence s_cmd_start;
        q.st == S_GAP ##1 q.st == S_CMD;
    endsequence
    a_auto_start: assert property ( // R1
        (q.st == S_IDLE && q.pend && q.cr2 && cfg_mode == M_ACTIVE && width_ok) |=> q.st == S_WAKE
    ) else $error("load did not start");
    a_reset_edge: assert property ( // R2
        (q.cr2 && !q.crp) |=> (q.pend || q.st == S_WAKE)
    ) else $error("config reset rise lost");
    a_clk_half: assert property ( // R3
        $rose(q.sclk) |-> q.sclk [*4]
    ) else $error("serial clock high too short");
    a_wake_opcode: assert property ( // R4
        $rose(q.st == S_WAKE) |-> (q.sh[31:24] == `SCL_OP_WAKE && !q.sel_n)
    ) else $error("first command is not wake");
    a_gap_select: assert property ( // R5
        s_wake_done |-> q.sel_n [*8]
    ) else $error("select low during wake gap");
    a_gap_length: assert property ( // R5
        s_cmd_start |-> $past(gap_q) == WAKE_END
    ) else $error("wake wait too short");
    a_read_addr: assert property ( // R6
        $rose(q.st == S_CMD) |-> (q.sh[23:0] == `SCL_ADDR0 && q.bits == `SCL_CMD_BITS)
    ) else $error("read not from address zero");
    a_done_gate: assert property ( // R7
        $rose(config_done) |-> (q.nbytes == IMG_BYTES && !config_ram_cells_valid)
    ) else $error("done before all bytes taken");
    a_bad_width: assert property ( // R9
        (q.st == S_IDLE && q.pend && q.cr2 && cfg_mode == M_ACTIVE && !width_ok) |=> (q.err && q.st == S_IDLE)
    ) else $error("illegal width not refused");
    a_user_pass: assert property ( // R10
        config_done |-> (flash.sclk == user.sclk && flash.flash_select_n == user.flash_select_n)
    ) else $error("user port not connected");
endmodule

/* File: testbench/scl_flash_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module scl_flash_model (
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic [3:0] io,
    input wire scl_pkg::scl_width_e width,
    output logic [3:0] drv,
    output logic [7:0] prev_op,
    output logic [7:0] rd_op,
    output logic [23:0] rd_addr,
    output logic [31:0] gap_ns,
    output logic [31:0] min_half_ns,
    output logic [31:0] n_sel,
    output logic [31:0] k
);
    import scl_pkg::*;
    logic [31:0] sr;
    logic [7:0] last_op;
    logic [7:0] tmp;
    int cnt;
    int pos;
    realtime t_wake;
    realtime t_edge;

    // image byte at offset n; a pattern that differs from byte to byte
    function automatic logic [7:0] img(input logic [31:0] n);
        return n[7:0] * 8'h1d + 8'h35;
    endfunction

    initial begin
        {drv, prev_op, rd_op, rd_addr, sr, last_op, gap_ns, n_sel, k} = '0;
        min_half_ns = 32'hffffffff;
        cnt = 0;
        pos = 0;
        t_wake = 0;
        t_edge = 0;
    end

    // shortest half period seen; the flash is rated for 20 mhz at most
    task automatic edge_seen();
        if (t_edge > 0 && $realtime - t_edge < min_half_ns) min_half_ns = int'($realtime - t_edge);
        t_edge = $realtime;
    endtask

    // a new frame restarts the bit count and reads from the top again
    always @(negedge sel_n) begin
        n_sel = n_sel + 1;
        cnt = 0;
        pos = 0;
        k = 0;
        if (last_op == 8'hab) gap_ns = int'($realtime - t_wake);
    end

    // a released lane shows the inverse of its last level, not a held copy
    always @(posedge sel_n) begin
        drv = ~drv;
        if (last_op == 8'hab) t_wake = $realtime;
    end

    // mode 0: opcode then address, msb first on io0, taken on rising sclk
    always @(posedge sclk) begin
        edge_seen();
        if (sel_n === 1'b0) begin
            sr = {sr[30:0], io[0]};
            cnt = cnt + 1;
            if (cnt == 8 && sr[7:0] != 8'hab) begin
                prev_op = last_op;
                rd_op = sr[7:0];
            end
            if (cnt == 8) last_op = sr[7:0];
            if (cnt == 32) rd_addr = sr[23:0];
        end
    end

    // after 8 dummy clocks data goes out on falling sclk, lanes by width
    always @(negedge sclk) begin
        edge_seen();
        if (sel_n === 1'b0 && cnt >= 40) begin
            tmp = img(k) << pos;
            case (width)
                W_X2: begin
                    drv[1:0] = tmp[7:6];
                    pos = pos + 2;
                end
                W_X4: begin
                    drv = tmp[7:4];
                    pos = pos + 4;
                end
                default: begin
                    drv[1] = tmp[7];
                    pos = pos + 1;
                end
            endcase
            if (pos == 8) begin
                pos = 0;
                k = k + 1;
            end
        end
    end
endmodule

/* File: testbench/scl_loader_tb_top.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module scl_loader_tb_top;
    import scl_pkg::*;
    localparam logic [31:0] NB = 32'd40;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic config_reset_n = 1'b1;
    scl_mode_e cfg_mode = M_ACTIVE;
    scl_width_e cfg_width = W_X1;
    scl_user_s user = 5'h01;
    logic config_ram_cells_ready = 1'b0;
    logic user_miso;
    scl_flash_s flash;
    logic [3:0] io_w;
    logic [3:0] drv;
    logic config_ram_cells_valid;
    logic [7:0] config_ram_cells_data;
    logic config_done;
    logic config_error;
    logic [7:0] prev_op;
    logic [7:0] rd_op;
    logic [23:0] rd_addr;
    logic [31:0] gap_ns;
    logic [31:0] min_half_ns;
    logic [31:0] n_sel;
    logic [31:0] k;
    int n_mismatch = 0;
    int compares = 0;

    always #4 mclk = ~mclk;

    // each lane shows the device where it drives, else the flash
    always_comb for (int i = 0; i < 4; i++) io_w[i] = flash.io_oe_n[i] ? drv[i] : flash.io_o[i];

    scl_loader #(.IMG_BYTES(NB), .HALF_CYC(4), .FIFO_DEPTH(32)) scl_loader_i (
        .mclk(mclk), .rstn(rstn), .config_reset_n(config_reset_n), .cfg_mode(cfg_mode),
        .cfg_width(cfg_width), .user(user), .user_miso(user_miso), .flash(flash), .flash_io_i(io_w),
        .config_ram_cells_valid(config_ram_cells_valid), .config_ram_cells_data(config_ram_cells_data), .config_ram_cells_ready(config_ram_cells_ready),
        .config_done(config_done), .config_error(config_error));

    scl_flash_model scl_flash_model_i (
        .sclk(flash.sclk), .sel_n(flash.flash_select_n), .io(io_w), .width(cfg_width), .drv(drv),
        .prev_op(prev_op), .rd_op(rd_op), .rd_addr(rd_addr), .gap_ns(gap_ns),
        .min_half_ns(min_half_ns), .n_sel(n_sel), .k(k));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] img(input logic [31:0] n);
        return n[7:0] * 8'h1d + 8'h35;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic give_up(input string what);
        n_mismatch++;
        $display("MISMATCH %s expected event seen timeout", what);
        conclude();
    endtask

    // hold the pin low long enough to pass the synchroniser, then release
    task automatic pulse_reset();
        @(posedge mclk) config_reset_n <= 1'b0;
        repeat (6) @(negedge mclk);
        chk("done_low", 32'h0, {31'h0, config_done});
        @(posedge mclk) config_reset_n <= 1'b1;
    endtask

    // full load: fill fifo with the stream stalled, then drain and compare
    task automatic load(input scl_width_e w, input logic [7:0] op, input bit trig);
        int n;
        int t;
        logic [31:0] k0;
        logic [31:0] s0;
        n = 0;
        t = 0;
        s0 = n_sel;
        @(posedge mclk) cfg_width <= w;
        cfg_mode <= M_ACTIVE;
        if (trig) pulse_reset();
        // byte count and opcodes still hold the last load until this one's wake and read frames open
        while (n_sel < s0 + 32'd2 || k < 32'd32) begin
            @(posedge mclk);
            if (++t > 20000) give_up("fill");
        end
        repeat (100) @(posedge mclk);
        k0 = k;
        repeat (200) @(posedge mclk);
        chk("stall", k0, k);
        chk("prev_op", 32'hab, {24'h0, prev_op});
        chk("read_op", {24'h0, op}, {24'h0, rd_op});
        chk("addr", 32'h0, {8'h0, rd_addr});
        chk("wake_gap", 32'h1, {31'h0, gap_ns >= 32'd30000});
        chk("sclk_half", 32'h1, {31'h0, min_half_ns >= 32'd25});
        chk("error_clear", 32'h0, {31'h0, config_error});
        @(posedge mclk) config_ram_cells_ready <= 1'b1;
        t = 0;
        while (n < NB) begin
            @(negedge mclk);
            if (++t > 20000) give_up("stream");
            if (config_ram_cells_valid === 1'b1) begin
                chk("config_ram_cells_byte", {24'h0, img(n)}, {24'h0, config_ram_cells_data});
                chk("done_early", 32'h0, {31'h0, config_done});
                n++;
            end
        end
        @(posedge mclk) config_ram_cells_ready <= 1'b0;
        t = 0;
        while (config_done !== 1'b1) begin
            @(negedge mclk);
            if (++t > 10) give_up("done");
        end
        chk("done_sel", 32'h1, {31'h0, flash.flash_select_n});
    endtask

    // starts that must not load: illegal active widths, passive and jtag
    task automatic no_load();
        scl_mode_e md[5] = '{M_ACTIVE, M_ACTIVE, M_ACTIVE, M_PASSIVE, M_JTAG};
        scl_width_e wd[5] = '{W_X8, W_X16, W_X32, W_X1, W_X1};
        logic [31:0] s0;
        foreach (md[i]) begin
            s0 = n_sel;
            @(posedge mclk) cfg_mode <= md[i];
            cfg_width <= wd[i];
            pulse_reset();
            repeat (50) @(negedge mclk);
            chk("no_frame", s0, n_sel);
            if (i < 3) chk("width_error", 32'h1, {31'h0, config_error});
        end
    endtask

    // after loading the flash pins follow the fabric port
    task automatic user_port();
        scl_user_s pat[2] = '{5'h15, 5'h0a};
        foreach (pat[i]) begin
            @(posedge mclk) user <= pat[i];
            repeat (4) @(negedge mclk);
            chk("user_pins", {27'h0, pat[i]}, {27'h0, flash.sclk, flash.io_o[0], flash.io_o[2],
                flash.io_o[3], flash.flash_select_n});
            chk("user_oe", 32'h2, {28'h0, flash.io_oe_n});
            chk("user_miso", {31'h0, io_w[1]}, {31'h0, user_miso});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        load(W_X1, 8'h0b, 1'b0);
        no_load();
        load(W_X2, 8'h3b, 1'b1);
        load(W_X4, 8'h6b, 1'b1);
        user_port();
        conclude();
    end
endmodule
